// ### design/qdac_consts.svh
// Widths, reset values and counts for the quad converter serial front end
`ifndef QDAC_CONSTS_SVH
`define QDAC_CONSTS_SVH

`define QDAC_CHANNELS      4
`define QDAC_CODE_BITS     16
`define QDAC_FRAME_BITS    24
`define QDAC_FIFO_DEPTH    4
`define QDAC_STRAP_WAIT    2'h3
`define QDAC_STRAP_TAKE    2'h1
`define QDAC_STRAP_DONE    2'h0

`endif

// ### design/qdac_pkg.sv
// Types shared by the quad converter serial front end
package qdac_pkg;

   // Levels caught from the strap pins after reset
   typedef struct packed {
      logic gainTwo;
      logic refHalve;
      logic resetMid;
   } qdac_straps_t;

   // Alarm sources that may drive the open-drain output
   typedef struct packed {
      logic crcError;
      logic refAlarm;
   } qdac_alarm_t;

endpackage

// ### design/qdac_serial_ctrl.sv
// Quad converter serial front end: link, straps, load strobe, frame FIFO
// How it works
// R01 - Code width 16, 14 or 12 bits; internal reference unless external.
// R02 - Gain strap caught after reset: low gives gain 1, high gain 2.
// R03 - Gain and halving straps caught once; later pin changes do nothing.
// R04 - Reset level select low resets channels to zero, high to midscale.
// R05 - Halving strap caught after reset: high divides the reference by 2.
// R06 - Falling load strobe updates every synchronous channel together.
// R07 - Load strobe held low forever still lets asynchronous channels work.
// R08 - Chip select low frames a transfer and enables the input shifter.
// R09 - One data bit enters the shifter on every falling serial clock.
// R10 - Data output floats whenever chip select is high.
// R11 - Shifter contents leave on rising or falling edges, as selected.
// R12 - Output pin may instead be an open-drain alarm for CRC or reference.
// R13 - Rising chip select ends the frame; the gathered word is then used.
`timescale 1ns/1ps

`include "qdac_consts.svh"

// ----------------------------------------------------------------------
// Frame FIFO
// ----------------------------------------------------------------------
module qdac_fifo #(
   parameter int WIDTH = `QDAC_FRAME_BITS,
   parameter int DEPTH = `QDAC_FIFO_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer wrap needs a power-of-two depth
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
      $error("qdac_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wrPtr;
      logic [AW:0]                 rdPtr;
   } qdac_fifo_st_t;

   qdac_fifo_st_t st_reg;
   qdac_fifo_st_t st_next;
   logic          full;
   logic          empty;

   assign full     = (st_reg.wrPtr[AW] != st_reg.rdPtr[AW]) &&
                     (st_reg.wrPtr[AW-1:0] == st_reg.rdPtr[AW-1:0]);
   assign empty    = (st_reg.wrPtr == st_reg.rdPtr);
   assign inReady  = !full;
   assign outValid = !empty;
   assign outData  = st_reg.mem[st_reg.rdPtr[AW-1:0]];

   always_comb begin
      st_next = st_reg;
      if (inValid && !full) begin
         st_next.mem[st_reg.wrPtr[AW-1:0]] = inData;
         st_next.wrPtr = st_reg.wrPtr + 1'b1;
      end
      if (outReady && !empty) begin
         st_next.rdPtr = st_reg.rdPtr + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule

// ----------------------------------------------------------------------
// Top
// ----------------------------------------------------------------------
module qdac_serial_ctrl
   import qdac_pkg::*;
#(
   parameter int CODE_BITS  = `QDAC_CODE_BITS,
   parameter int FRAME_BITS = `QDAC_FRAME_BITS,
   parameter int FIFO_DEPTH = `QDAC_FIFO_DEPTH
) (
   input  wire logic                               clk,
   input  wire logic                               rst,
   input  wire logic                               sclk,
   input  wire logic                               csN,
   input  wire logic                               sdi,
   output logic                                    sdoOut,
   output logic                                    sdoOe,
   input  wire logic                               readbackEdgeSelect,
   input  wire logic                               alarmMode,
   input  wire qdac_alarm_t                        alarmIn,
   input  wire logic                               gainStrap,
   input  wire logic                               referenceHalvingStrap,
   input  wire logic                               resetLevelSelect,
   input  wire logic                               loadOutputsStrobe,
   input  wire logic                               refSelect,
   input  wire logic [`QDAC_CHANNELS-1:0]          syncMode,
   input  wire logic [`QDAC_CHANNELS-1:0]          chanWrite,
   input  wire logic [CODE_BITS-1:0]               chanData,
   output qdac_straps_t                            straps,
   output logic                                    refExternal,
   output logic [`QDAC_CHANNELS-1:0][CODE_BITS-1:0] chanCode,
   output logic [FRAME_BITS-1:0]                   frameData,
   output logic                                    frameValid,
   input  wire logic                               frameReady
);
   localparam int CW = $clog2(FRAME_BITS);
   localparam int NC = `QDAC_CHANNELS;

   // Only the three code widths of the family are served
   if (CODE_BITS != 16 && CODE_BITS != 14 && CODE_BITS != 12) begin : g_cw
      $error("qdac_serial_ctrl: CODE_BITS must be 16, 14 or 12"); // R01
   end
   if (FRAME_BITS < 2) begin : g_fb
      $error("qdac_serial_ctrl: FRAME_BITS must be at least 2");
   end

   // -------------------------------------------------------------------
   // Link side, clocked by the serial clock
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [CW-1:0]         bitCnt;
      logic [FRAME_BITS-1:0] shift;
      logic [FRAME_BITS-1:0] word;
      logic                  wordFull;
      logic                  sdoFall;
   } qdac_link_t;

   qdac_link_t ln_reg;
   qdac_link_t ln_next;
   logic       sdoRise_reg;

   always_comb begin
      ln_next = ln_reg;
      ln_next.shift = {ln_reg.shift[FRAME_BITS-2:0], sdi}; // R09
      ln_next.sdoFall = ln_reg.shift[FRAME_BITS-1]; // R11
      // Word complete after FRAME_BITS falling edges
      if (ln_reg.bitCnt == CW'(FRAME_BITS - 1)) begin
         ln_next.bitCnt = '0;
         ln_next.word = {ln_reg.shift[FRAME_BITS-2:0], sdi};
         ln_next.wordFull = 1'b1;
      end else begin
         ln_next.bitCnt = ln_reg.bitCnt + 1'b1;
         if (ln_reg.bitCnt == '0) begin
            ln_next.wordFull = 1'b0;
         end
      end
   end

   // Chip select high holds the bit counter at zero between frames
   always_ff @(negedge sclk or posedge csN) begin
      if (csN) begin
         ln_reg.bitCnt <= '0; // R08
      end else begin
         ln_reg <= ln_next;
      end
   end

   // Rising-edge copy for readback on the rising clock
   always_ff @(posedge sclk) begin
      sdoRise_reg <= ln_reg.shift[FRAME_BITS-1]; // R11
   end

   // -------------------------------------------------------------------
   // Control side, clocked by clk
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [1:0]                       csSync;
      logic [1:0]                       fullSync;
      logic [1:0]                       loadSync;
      logic                             loadPrev;
      logic [1:0]                       gainSync;
      logic [1:0]                       halfSync;
      logic [1:0]                       rlevSync;
      logic [1:0]                       refSelSync;
      logic                             csPrev;
      logic [1:0]                       strapCnt;
      qdac_straps_t                     straps;
      logic                             refExt;
      logic [NC-1:0][CODE_BITS-1:0]     buffered;
      logic [NC-1:0][CODE_BITS-1:0]     active;
      logic                             alarmDrive;
      logic                             pushPend;
      logic [FRAME_BITS-1:0]            pushData;
   } qdac_ctrl_t;

   qdac_ctrl_t st_reg;
   qdac_ctrl_t st_next;
   logic       fifoInReady;
   logic       csRise;
   logic       loadFall;
   logic [CODE_BITS-1:0] resetCode;

   assign csRise   = st_reg.csSync[1] && !st_reg.csPrev;
   assign loadFall = !st_reg.loadSync[1] && st_reg.loadPrev;
   assign resetCode = st_reg.rlevSync[1] ?
                      {1'b1, {(CODE_BITS-1){1'b0}}} : '0; // R04

   always_comb begin
      st_next = st_reg;
      st_next.csSync     = {st_reg.csSync[0], csN};
      st_next.fullSync   = {st_reg.fullSync[0], ln_reg.wordFull};
      st_next.loadSync   = {st_reg.loadSync[0], loadOutputsStrobe};
      st_next.gainSync   = {st_reg.gainSync[0], gainStrap};
      st_next.halfSync   = {st_reg.halfSync[0], referenceHalvingStrap};
      st_next.rlevSync   = {st_reg.rlevSync[0], resetLevelSelect};
      st_next.refSelSync = {st_reg.refSelSync[0], refSelect};
      st_next.csPrev     = st_reg.csSync[1];
      st_next.loadPrev   = st_reg.loadSync[1];
      st_next.refExt     = st_reg.refSelSync[1]; // R01

      // Straps are taken once, after the sync chain has filled
      if (st_reg.strapCnt != `QDAC_STRAP_DONE) begin
         st_next.strapCnt = st_reg.strapCnt - 2'h1;
      end
      if (st_reg.strapCnt == `QDAC_STRAP_TAKE) begin // R03
         st_next.straps.gainTwo  = st_reg.gainSync[1]; // R02
         st_next.straps.refHalve = st_reg.halfSync[1]; // R05
         st_next.straps.resetMid = st_reg.rlevSync[1]; // R04
         for (int i = 0; i < NC; i++) begin
            st_next.buffered[i] = resetCode; // R04
            st_next.active[i]   = resetCode; // R04
         end
      end else begin
         for (int i = 0; i < NC; i++) begin
            if (chanWrite[i]) begin
               st_next.buffered[i] = chanData;
               if (!syncMode[i]) begin
                  st_next.active[i] = chanData; // R07
               end
            end
            if (loadFall && syncMode[i]) begin
               st_next.active[i] = st_reg.buffered[i]; // R06
            end
         end
      end

      st_next.alarmDrive = alarmMode &&
                           (alarmIn.crcError || alarmIn.refAlarm); // R12

      // Frame end hands the gathered word to the FIFO
      if (st_reg.pushPend && fifoInReady) begin
         st_next.pushPend = 1'b0;
      end
      // Set wins over a clear in the same cycle
      if (csRise && st_reg.fullSync[1] &&
          (!st_reg.pushPend || fifoInReady)) begin // R13
         st_next.pushData = ln_reg.word;
         st_next.pushPend = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
         st_reg.csSync   <= 2'h3;
         st_reg.csPrev   <= 1'b1;
         st_reg.loadSync <= 2'h3;
         st_reg.loadPrev <= 1'b1;
         st_reg.strapCnt <= `QDAC_STRAP_WAIT;
      end else begin
         st_reg <= st_next;
      end
   end

   // -------------------------------------------------------------------
   // Buffering and pins
   // -------------------------------------------------------------------
   qdac_fifo #(
      .WIDTH (FRAME_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .inData   (st_reg.pushData),
      .inValid  (st_reg.pushPend),
      .inReady  (fifoInReady),
      .outData  (frameData),
      .outValid (frameValid),
      .outReady (frameReady)
   );

   assign straps      = st_reg.straps;
   assign refExternal = st_reg.refExt;
   assign chanCode    = st_reg.active;

   // Alarm mode pulls low only; data mode floats while deselected
   assign sdoOut = alarmMode ? 1'b0 :
                   (readbackEdgeSelect ? sdoRise_reg : ln_reg.sdoFall); // R11
   assign sdoOe  = alarmMode ? st_reg.alarmDrive : !csN; // R10 R12

endmodule

// ### verification/qdac_host_model.sv
// Serial host model: frames, 6 ns link clock, readback capture
`timescale 1ns/1ps
module qdac_host_model (
   output logic      sclk,
   output logic      csN,
   output logic      sdi,
   input  wire logic sdoOut,
   input  wire logic rbRise
);
   logic [23:0] rbWord;
   initial begin
      sclk = 1'b0;
      csN = 1'b1;
      sdi = 1'b0;
      rbWord = 24'h0;
   end
   // Clock stands still outside frames
   task automatic send(input logic [23:0] w, input int n);
      csN = 1'b0;
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         sdi = w[i];
         #1.5 sclk = 1'b1;
         #1 if (rbRise) rbWord = {rbWord[22:0], sdoOut};
         #0.5 sclk = 1'b0;
         #1 if (!rbRise) rbWord = {rbWord[22:0], sdoOut};
         #2;
      end
      csN = 1'b1;
      sdi = ~sdi;
      #40;
   endtask
endmodule

// ### verification/qdac_serial_ctrl_asserts.sv
// Port assertions for the quad converter serial front end
`timescale 1ns/1ps
`include "qdac_consts.svh"
module qdac_serial_ctrl_asserts
   import qdac_pkg::*;
#(
   parameter int CODE_BITS  = 16,
   parameter int FRAME_BITS = 24
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic csN,
   input wire logic sdoOut,
   input wire logic sdoOe,
   input wire logic alarmMode,
   input wire qdac_alarm_t alarmIn,
   input wire logic refSelect,
   input wire logic loadOutputsStrobe,
   input wire logic [`QDAC_CHANNELS-1:0] syncMode,
   input wire logic [`QDAC_CHANNELS-1:0] chanWrite,
   input wire logic [CODE_BITS-1:0] chanData,
   input wire qdac_straps_t straps,
   input wire logic refExternal,
   input wire logic [`QDAC_CHANNELS-1:0][CODE_BITS-1:0] chanCode,
   input wire logic [FRAME_BITS-1:0] frameData,
   input wire logic frameValid,
   input wire logic frameReady
);
   // ----
   // Settled after strap capture
   // ----
   logic [2:0] sinceRst;
   logic       live;
   assign live = (sinceRst == 3'h7);
   always_ff @(posedge clk) begin
      if (rst)
         sinceRst <= 3'h0;
      else if (!live)
         sinceRst <= sinceRst + 3'h1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence refSteady;
      (live && $stable(refSelect)) [*4];
   endsequence
   sequence syncIdle;
      (live && syncMode[1] && loadOutputsStrobe) [*6];
   endsequence
   a_sdo_float: assert property (!alarmMode && csN |-> !sdoOe)
      else $error("sdo driven while idle");
   a_alarm_low: assert property (alarmMode && sdoOe |-> !sdoOut)
      else $error("alarm drives high");
   a_alarm_drive: assert property (
      live && alarmMode && $past(alarmMode) |-> sdoOe == $past(|alarmIn))
      else $error("alarm pin wrong");
   a_straps_once: assert property (
      live && $past(live) |-> $stable(straps))
      else $error("straps changed");
   a_async_write: assert property (
      live && chanWrite[0] && !syncMode[0] |=> chanCode[0] == $past(chanData))
      else $error("async write lost");
   a_sync_wait: assert property (syncIdle |-> $stable(chanCode[1]))
      else $error("sync channel moved");
   a_fifo_hold: assert property (
      frameValid && !frameReady |=> frameValid && $stable(frameData))
      else $error("frame head moved");
   a_ref_follow: assert property (
      refSteady |-> refExternal == refSelect)
      else $error("reference select lost");
endmodule
bind qdac_serial_ctrl qdac_serial_ctrl_asserts #(
   .CODE_BITS(CODE_BITS), .FRAME_BITS(FRAME_BITS)
) u_asserts (
   .clk(clk), .rst(rst), .csN(csN), .sdoOut(sdoOut), .sdoOe(sdoOe),
   .alarmMode(alarmMode), .alarmIn(alarmIn), .refSelect(refSelect),
   .loadOutputsStrobe(loadOutputsStrobe), .syncMode(syncMode),
   .chanWrite(chanWrite), .chanData(chanData), .straps(straps),
   .refExternal(refExternal), .chanCode(chanCode), .frameData(frameData),
   .frameValid(frameValid), .frameReady(frameReady)
);

// ### verification/test_qdac_serial_ctrl.sv
// Bench for the quad converter serial front end
`timescale 1ns/1ps
module test_qdac_serial_ctrl import qdac_pkg::*;;
   logic clk, rst, sclk, csN, sdi, sdoOut, sdoOe, frameValid, frameReady;
   logic readbackEdgeSelect, alarmMode, gainStrap, resetLevelSelect;
   logic referenceHalvingStrap, loadOutputsStrobe, refSelect, refExternal;
   logic [3:0] syncMode, chanWrite;
   logic [15:0] chanData;
   logic [3:0][15:0] chanCode;
   logic [23:0] frameData;
   logic [23:0] w [4] = '{24'hA5C3F0, 24'h123456, 24'hFFFF00, 24'h0F0F81};
   qdac_alarm_t alarmIn;
   qdac_straps_t straps;
   int err_count = 0, total_checks = 0;
   qdac_serial_ctrl uut (.clk(clk), .rst(rst), .sclk(sclk), .csN(csN),
      .sdi(sdi), .sdoOut(sdoOut), .sdoOe(sdoOe), .alarmMode(alarmMode),
      .readbackEdgeSelect(readbackEdgeSelect), .alarmIn(alarmIn),
      .gainStrap(gainStrap), .resetLevelSelect(resetLevelSelect),
      .referenceHalvingStrap(referenceHalvingStrap), .straps(straps),
      .loadOutputsStrobe(loadOutputsStrobe), .refSelect(refSelect),
      .syncMode(syncMode), .chanWrite(chanWrite), .chanData(chanData),
      .refExternal(refExternal), .chanCode(chanCode),
      .frameData(frameData), .frameValid(frameValid),
      .frameReady(frameReady));
   qdac_host_model host (.sclk(sclk), .csN(csN), .sdi(sdi),
      .sdoOut(sdoOut), .rbRise(readbackEdgeSelect));
   // ----
   // Tests
   // ----
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic t_straps();
      logic s;
      for (int k = 0; k < 2; k++) begin
         s = k[0];
         gainStrap = !s;
         referenceHalvingStrap = s;
         resetLevelSelect = !s;
         rst = 1'b1;
         repeat (2) @(negedge clk);
         rst = 1'b0;
         repeat (6) @(negedge clk);
         chk(straps, {!s, s, !s});
         chk(chanCode[2], s ? 16'h0000 : 16'h8000);
         gainStrap = s;
         referenceHalvingStrap = !s;
         repeat (6) @(negedge clk);
         chk(straps, {!s, s, !s});
      end
      $display("test straps done");
   endtask
   task automatic t_chan();
      loadOutputsStrobe = 1'b0;
      // Strobe now stays low: the write below sees no edge
      repeat (4) @(negedge clk);
      chanData = 16'h1234;
      chanWrite = 4'h3;
      @(negedge clk);
      chanWrite = 4'h0;
      repeat (4) @(negedge clk);
      chk(chanCode[0], 16'h1234);
      chk(chanCode[1], 16'h0000);
      loadOutputsStrobe = 1'b1;
      refSelect = 1'b1;
      repeat (8) @(negedge clk);
      chk(chanCode[1], 16'h0000);
      loadOutputsStrobe = 1'b0;
      repeat (5) @(negedge clk);
      chk(chanCode[1], 16'h1234);
      chk(refExternal, 1'b1);
      $display("test channels done");
   endtask
   task automatic t_link();
      int n;
      // First cut frame clears the word-full flag, second must be dropped
      repeat (2) host.send(24'h7FFFFF, 23);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         readbackEdgeSelect = i[0];
         host.send(w[i], 24);
         if (i > 0) chk(host.rbWord, w[i-1]);
      end
      chk(sdoOe, 1'b0);
      for (int i = 0; i < 4; i++) begin
         n = 0;
         while (frameValid !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
         end
         chk(frameData, w[i]);
         frameReady = 1'b1;
         @(negedge clk);
         frameReady = 1'b0;
         @(negedge clk);
      end
      chk(frameValid, 1'b0);
      $display("test link done");
   endtask
   task automatic t_alarm();
      alarmMode = 1'b1;
      for (int i = 1; i < 4; i++) begin
         alarmIn = i[1:0];
         repeat (3) @(negedge clk);
         chk({sdoOe, sdoOut}, 2'b10);
      end
      alarmIn = 2'b00;
      repeat (3) @(negedge clk);
      chk(sdoOe, 1'b0);
      $display("test alarm done");
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #20000;
      err_count++;
      final_report();
   end
   initial begin
      {rst, readbackEdgeSelect, alarmMode, frameReady, refSelect} = 5'h10;
      {gainStrap, referenceHalvingStrap, resetLevelSelect} = 3'h0;
      loadOutputsStrobe = 1'b1;
      alarmIn = 2'h0;
      syncMode = 4'h2;
      chanWrite = 4'h0;
      chanData = 16'h0000;
      t_straps();
      t_chan();
      t_link();
      t_alarm();
      final_report();
   end
endmodule
